// ===== rtl/lcie_line_channel_irq.sv
/*
 * Interrupt trigger and mask logic for sixteen line interface channels:
 * per channel an edge select register, two mask registers, live status
 * read-back and two write-one-to-clear sticky status registers, all
 * merged into one interrupt level.
 * Assumes the detectors deliver their live status bits synchronous to
 * ref_clk, and a register master that issues one-cycle strobes.
 */
// Chosen here: the plain strobed port.
// Contract
// [RL1] Alarm-indication edge select: rising or any edge.
// [RL2] Pattern-sync edge select: rising or any edge.
// [RL3] Overcurrent edge select: rising or any edge.
// [RL4] Transmit clock missing edge select likewise.
// [RL5] Transmit loss edge select: rising or any.
// [RL6] Signal loss select covers line and system.
// [RL7] Inband select covers activate and deactivate codes.
// [RL8] Mask zero enables; all masks reset set.
// [RL9] First mask bit 7 gates amplitude overflow.
// [RL10] First mask bit 6 gates transmit jitter FIFO.
// [RL11] First mask bit 5 gates receive jitter FIFO.
// [RL12] First mask bit 4 gates driver overcurrent.
// [RL13] First mask bit 3 gates missing transmit clock.
// [RL14] First mask bit 2 gates transmit loss.
// [RL15] First mask bit 1 gates system loss.
// [RL16] First mask bit 0 gates line loss.
// [RL17] Second mask bit 7 gates system alarm.
// [RL18] Second mask bit 6 gates line alarm.
// [RL19] Second bit 5 gates pattern; 4-2 reserved.
// [RL20] Second mask bit 1 gates activate code.
// [RL21] Second mask bit 0 gates deactivate code.
// [RL22] Writing one clears a sticky status flag.
// [RL23] Unmasked set sticky flag drives interrupt output.
// [RL24] Transitions found against previous clock's live value.
// [RL25] Sixteen channel copies spaced 0x40 apart.
`timescale 1ns/100ps
`default_nettype none

module lcie_line_channel_irq (
    input  wire logic                                        ref_clk,
    input  wire logic                                        nrst,
    input  wire lcie_pkg::lcie_bus_req_s                     busReq,
    output logic [7:0]                                       busRdData,
    input  wire lcie_pkg::lcie_pair_s [lcie_pkg::CH_NUM-1:0] liveStatus,
    output logic                                             irqOut
);

    // ************************************************************
    // Declarations
    // ************************************************************
    lcie_pkg::lcie_top_state_s                   state_ff;
    lcie_pkg::lcie_top_state_s                   nxt_state;
    lcie_pkg::lcie_reg_e                         busSel;
    logic [lcie_pkg::CH_W-1:0]                   busCh;
    logic [7:0]                                  rdValue;
    lcie_pkg::lcie_pair_s [lcie_pkg::CH_NUM-1:0] anyEdgeVec;
    lcie_pkg::lcie_pair_s [lcie_pkg::CH_NUM-1:0] clearVec;
    lcie_pkg::lcie_pair_s [lcie_pkg::CH_NUM-1:0] stickyVec;
    lcie_pkg::lcie_pair_s [lcie_pkg::CH_NUM-1:0] liveSeenVec;
    lcie_pkg::lcie_pair_s [lcie_pkg::CH_NUM-1:0] maskVec;

    // ************************************************************
    // Functions
    // ************************************************************

    // Maps a channel-local offset onto the register it selects.
    function automatic lcie_pkg::lcie_reg_e decodeReg(input logic [lcie_pkg::CH_LSB-1:0] offset);
        lcie_pkg::lcie_reg_e sel;
        sel = lcie_pkg::REG_NONE;
        case (offset)
            lcie_pkg::OFF_EDGE_SEL: begin
                sel = lcie_pkg::REG_EDGE_SEL;
            end
            lcie_pkg::OFF_MASK_FIRST: begin
                sel = lcie_pkg::REG_MASK_FIRST;
            end
            lcie_pkg::OFF_MASK_SECOND: begin
                sel = lcie_pkg::REG_MASK_SECOND;
            end
            lcie_pkg::OFF_LIVE_FIRST: begin
                sel = lcie_pkg::REG_LIVE_FIRST;
            end
            lcie_pkg::OFF_LIVE_SECOND: begin
                sel = lcie_pkg::REG_LIVE_SECOND;
            end
            lcie_pkg::OFF_STICKY_FIRST: begin
                sel = lcie_pkg::REG_STICKY_FIRST;
            end
            lcie_pkg::OFF_STICKY_SECOND: begin
                sel = lcie_pkg::REG_STICKY_SECOND;
            end
            default: begin
                sel = lcie_pkg::REG_NONE;
            end
        endcase
        return sel;
    endfunction

    // Spreads the seven edge select bits over the sticky bits they steer.
    // A zero bit means rising edge only; a one means either edge. The three
    // FIFO and amplitude events have no select bit and always take rising.
    function automatic lcie_pkg::lcie_pair_s expandEdgeSel(input logic [7:0] sel);
        lcie_pkg::lcie_pair_s any;
        any = '0;
        any.second[lcie_pkg::S_SYS_ALARM]  = sel[lcie_pkg::ES_ALARM_IND];    // RL1
        any.second[lcie_pkg::S_LINE_ALARM] = sel[lcie_pkg::ES_ALARM_IND];    // RL1
        any.second[lcie_pkg::S_PATTERN]    = sel[lcie_pkg::ES_PATTERN];      // RL2
        any.first[lcie_pkg::F_OVERCUR]     = sel[lcie_pkg::ES_OVERCUR];      // RL3
        any.first[lcie_pkg::F_TXCLK]       = sel[lcie_pkg::ES_TXCLK];        // RL4
        any.first[lcie_pkg::F_TXLOSS]      = sel[lcie_pkg::ES_TXLOSS];       // RL5
        any.first[lcie_pkg::F_LINE_LOSS]   = sel[lcie_pkg::ES_SIGLOSS];      // RL6
        any.first[lcie_pkg::F_SYS_LOSS]    = sel[lcie_pkg::ES_SIGLOSS];      // RL6
        any.second[lcie_pkg::S_ACTIVATE]   = sel[lcie_pkg::ES_INBAND];       // RL7
        any.second[lcie_pkg::S_DEACTIVATE] = sel[lcie_pkg::ES_INBAND];       // RL7
        return any;
    endfunction

    // ************************************************************
    // Address decode
    // ************************************************************

    // The channel number sits above the 64-byte channel window, so every
    // channel sees the same local offsets.
    assign busCh  = busReq.addr[lcie_pkg::ADDR_W-1:lcie_pkg::CH_LSB];          // RL25
    assign busSel = decodeReg(busReq.addr[lcie_pkg::CH_LSB-1:0]);              // RL25

    // ************************************************************
    // Read multiplexer
    // ************************************************************
    always_comb begin
        rdValue = lcie_pkg::RD_IDLE;
        case (busSel)
            lcie_pkg::REG_EDGE_SEL: begin
                rdValue = state_ff.edgeSel[busCh];
            end
            lcie_pkg::REG_MASK_FIRST: begin
                rdValue = state_ff.maskFirst[busCh];
            end
            lcie_pkg::REG_MASK_SECOND: begin
                rdValue = state_ff.maskSecond[busCh];
            end
            lcie_pkg::REG_LIVE_FIRST: begin
                rdValue = liveSeenVec[busCh].first & lcie_pkg::LIVE_FIRST_VALID;
            end
            lcie_pkg::REG_LIVE_SECOND: begin
                rdValue = liveSeenVec[busCh].second;
            end
            lcie_pkg::REG_STICKY_FIRST: begin
                rdValue = stickyVec[busCh].first;
            end
            lcie_pkg::REG_STICKY_SECOND: begin
                rdValue = stickyVec[busCh].second;
            end
            default: begin
                rdValue = lcie_pkg::RD_IDLE;
            end
        endcase
    end

    // ************************************************************
    // Register state update
    // ************************************************************

    // Reserved bits are dropped on write so they always read back as zero.
    always_comb begin
        nxt_state        = state_ff;
        nxt_state.rdData = lcie_pkg::RD_IDLE;
        if (busReq.wrStb) begin
            case (busSel)
                lcie_pkg::REG_EDGE_SEL: begin
                    nxt_state.edgeSel[busCh] = busReq.wrData & lcie_pkg::EDGE_SEL_VALID;
                end
                lcie_pkg::REG_MASK_FIRST: begin
                    nxt_state.maskFirst[busCh] = busReq.wrData;
                end
                lcie_pkg::REG_MASK_SECOND: begin
                    nxt_state.maskSecond[busCh] = busReq.wrData & lcie_pkg::SECOND_VALID;  // RL19
                end
                default: begin
                    nxt_state.rdData = lcie_pkg::RD_IDLE;
                end
            endcase
        end
        if (busReq.rdStb) begin
            nxt_state.rdData = rdValue;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            for (int c = 0; c < lcie_pkg::CH_NUM; c++) begin
                state_ff.edgeSel[c]    <= lcie_pkg::EDGE_SEL_RST;
                state_ff.maskFirst[c]  <= lcie_pkg::MASK_FIRST_RST;                // RL8
                state_ff.maskSecond[c] <= lcie_pkg::MASK_SECOND_RST;               // RL8
            end
            state_ff.rdData <= lcie_pkg::RD_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Read data is zero outside the cycle after a read strobe.
    assign busRdData = state_ff.rdData;

    // ************************************************************
    // Per-channel trigger logic
    // ************************************************************
    generate
        for (genvar c = 0; c < lcie_pkg::CH_NUM; c++) begin : g_chan
            logic hitCh;

            assign hitCh = busReq.wrStb && (busCh == lcie_pkg::CH_W'(c));

            // Write-one-to-clear: only the bits written as one are cleared.
            assign clearVec[c].first  = (hitCh && busSel == lcie_pkg::REG_STICKY_FIRST) ?
                                        busReq.wrData : 8'h00;                     // RL22
            assign clearVec[c].second = (hitCh && busSel == lcie_pkg::REG_STICKY_SECOND) ?
                                        busReq.wrData : 8'h00;                     // RL22

            assign anyEdgeVec[c] = expandEdgeSel(state_ff.edgeSel[c]);

            // Mask bit positions follow the sticky bit positions one for one.
            assign maskVec[c].first[lcie_pkg::F_AMPLITUDE] =
                state_ff.maskFirst[c][lcie_pkg::F_AMPLITUDE];                      // RL9
            assign maskVec[c].first[lcie_pkg::F_TX_JITTER] =
                state_ff.maskFirst[c][lcie_pkg::F_TX_JITTER];                      // RL10
            assign maskVec[c].first[lcie_pkg::F_RX_JITTER] =
                state_ff.maskFirst[c][lcie_pkg::F_RX_JITTER];                      // RL11
            assign maskVec[c].first[lcie_pkg::F_OVERCUR] =
                state_ff.maskFirst[c][lcie_pkg::F_OVERCUR];                        // RL12
            assign maskVec[c].first[lcie_pkg::F_TXCLK] =
                state_ff.maskFirst[c][lcie_pkg::F_TXCLK];                          // RL13
            assign maskVec[c].first[lcie_pkg::F_TXLOSS] =
                state_ff.maskFirst[c][lcie_pkg::F_TXLOSS];                         // RL14
            assign maskVec[c].first[lcie_pkg::F_SYS_LOSS] =
                state_ff.maskFirst[c][lcie_pkg::F_SYS_LOSS];                       // RL15
            assign maskVec[c].first[lcie_pkg::F_LINE_LOSS] =
                state_ff.maskFirst[c][lcie_pkg::F_LINE_LOSS];                      // RL16

            // Reserved sticky bits never set, so their mask positions are
            // held masked rather than left to chance.
            assign maskVec[c].second = state_ff.maskSecond[c] | ~lcie_pkg::SECOND_VALID;  // RL17 RL18 RL19 RL20 RL21

            lcie_chan_events u_events (
                .ref_clk        (ref_clk),
                .nrst           (nrst),
                .liveIn         (liveStatus[c]),
                .anyEdge        (anyEdgeVec[c]),
                .clearVec       (clearVec[c]),
                .stickyFirst    (stickyVec[c].first),
                .stickySecond   (stickyVec[c].second),
                .liveSeenFirst  (liveSeenVec[c].first),
                .liveSeenSecond (liveSeenVec[c].second)
            );
        end
    endgenerate

    // ************************************************************
    // Interrupt merge
    // ************************************************************
    lcie_irq_gate u_gate (
        .ref_clk   (ref_clk),
        .nrst      (nrst),
        .stickyVec (stickyVec),
        .maskVec   (maskVec),
        .irqOut    (irqOut)
    );

endmodule

`default_nettype wire

// ===== inc/lcie_pkg.sv
/*
 * Shared constants and types for the per-channel interrupt trigger block:
 * register offsets inside a channel, field positions, reset values,
 * register selections and the packed carriers that join the modules.
 * Assumes channels repeat every 64 bytes of the 10-bit register address.
 */
`default_nettype none

package lcie_pkg;

    // ************************************************************
    // Geometry
    // ************************************************************
    localparam int CH_NUM = 16;
    localparam int CH_W   = 4;
    localparam int CH_LSB = 6;
    localparam int ADDR_W = 10;

    // ************************************************************
    // Register offsets inside one channel
    // ************************************************************
    localparam logic [CH_LSB-1:0] OFF_EDGE_SEL      = 6'h1a;
    localparam logic [CH_LSB-1:0] OFF_MASK_FIRST    = 6'h1b;
    localparam logic [CH_LSB-1:0] OFF_MASK_SECOND   = 6'h1c;
    localparam logic [CH_LSB-1:0] OFF_LIVE_FIRST    = 6'h1e;
    localparam logic [CH_LSB-1:0] OFF_LIVE_SECOND   = 6'h1f;
    localparam logic [CH_LSB-1:0] OFF_STICKY_FIRST  = 6'h20;
    localparam logic [CH_LSB-1:0] OFF_STICKY_SECOND = 6'h21;

    // ************************************************************
    // Reset values and implemented-bit masks
    // ************************************************************
    localparam logic [7:0] EDGE_SEL_RST      = 8'h00;
    localparam logic [7:0] MASK_FIRST_RST    = 8'hff;
    localparam logic [7:0] MASK_SECOND_RST   = 8'he3;
    localparam logic [7:0] EDGE_SEL_VALID    = 8'h7f;
    localparam logic [7:0] SECOND_VALID      = 8'he3;
    localparam logic [7:0] LIVE_FIRST_VALID  = 8'h1f;
    localparam logic [7:0] RD_IDLE           = 8'h00;

    // ************************************************************
    // Edge select field positions
    // ************************************************************
    localparam int ES_ALARM_IND = 6;
    localparam int ES_PATTERN   = 5;
    localparam int ES_OVERCUR   = 4;
    localparam int ES_TXCLK     = 3;
    localparam int ES_TXLOSS    = 2;
    localparam int ES_SIGLOSS   = 1;
    localparam int ES_INBAND    = 0;

    // ************************************************************
    // First group positions (masks, live and sticky alike)
    // ************************************************************
    localparam int F_AMPLITUDE = 7;
    localparam int F_TX_JITTER = 6;
    localparam int F_RX_JITTER = 5;
    localparam int F_OVERCUR   = 4;
    localparam int F_TXCLK     = 3;
    localparam int F_TXLOSS    = 2;
    localparam int F_SYS_LOSS  = 1;
    localparam int F_LINE_LOSS = 0;

    // ************************************************************
    // Second group positions
    // ************************************************************
    localparam int S_SYS_ALARM  = 7;
    localparam int S_LINE_ALARM = 6;
    localparam int S_PATTERN    = 5;
    localparam int S_ACTIVATE   = 1;
    localparam int S_DEACTIVATE = 0;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [2:0] {
        REG_NONE          = 3'h0,
        REG_EDGE_SEL      = 3'h1,
        REG_MASK_FIRST    = 3'h3,
        REG_MASK_SECOND   = 3'h2,
        REG_LIVE_FIRST    = 3'h6,
        REG_LIVE_SECOND   = 3'h7,
        REG_STICKY_FIRST  = 3'h5,
        REG_STICKY_SECOND = 3'h4
    } lcie_reg_e;

    typedef struct packed {
        logic [7:0] first;
        logic [7:0] second;
    } lcie_pair_s;

    typedef struct packed {
        logic              wrStb;
        logic              rdStb;
        logic [ADDR_W-1:0] addr;
        logic [7:0]        wrData;
    } lcie_bus_req_s;

    typedef struct packed {
        logic [CH_NUM-1:0][7:0] edgeSel;
        logic [CH_NUM-1:0][7:0] maskFirst;
        logic [CH_NUM-1:0][7:0] maskSecond;
        logic [7:0]             rdData;
    } lcie_top_state_s;

    typedef struct packed {
        lcie_pair_s prev;
        lcie_pair_s sticky;
    } lcie_chan_state_s;

    typedef struct packed {
        logic irq;
    } lcie_gate_state_s;

endpackage

`default_nettype wire

// ===== rtl/lcie_chan_events.sv
/*
 * One channel's transition detector and sticky interrupt status bits.
 * Assumes live inputs are synchronous to ref_clk and that clear vectors
 * are one-cycle pulses from the register decoder.
 */
`timescale 1ns/100ps
`default_nettype none

module lcie_chan_events (
    input  wire logic                 ref_clk,
    input  wire logic                 nrst,
    input  wire lcie_pkg::lcie_pair_s liveIn,
    input  wire lcie_pkg::lcie_pair_s anyEdge,
    input  wire lcie_pkg::lcie_pair_s clearVec,
    output logic [7:0]                stickyFirst,
    output logic [7:0]                stickySecond,
    output logic [7:0]                liveSeenFirst,
    output logic [7:0]                liveSeenSecond
);

    lcie_pkg::lcie_chan_state_s state_ff;
    lcie_pkg::lcie_chan_state_s nxt_state;
    lcie_pkg::lcie_pair_s       setVec;

    // ************************************************************
    // Transition detection and sticky update
    // ************************************************************
    always_comb begin
        setVec.first  = anyEdge.first & (liveIn.first ^ state_ff.prev.first) |          // RL24
                        ~anyEdge.first & liveIn.first & ~state_ff.prev.first;
        setVec.second = (anyEdge.second & (liveIn.second ^ state_ff.prev.second) |
                        ~anyEdge.second & liveIn.second & ~state_ff.prev.second) &
                        lcie_pkg::SECOND_VALID;
        nxt_state.prev          = liveIn;                                               // RL24
        // A set in the same cycle as a clear wins, so no event is lost.
        nxt_state.sticky.first  = (state_ff.sticky.first & ~clearVec.first) | setVec.first;    // RL22
        nxt_state.sticky.second = (state_ff.sticky.second & ~clearVec.second) | setVec.second; // RL22
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign stickyFirst    = state_ff.sticky.first;
    assign stickySecond   = state_ff.sticky.second;
    assign liveSeenFirst  = state_ff.prev.first;
    assign liveSeenSecond = state_ff.prev.second & lcie_pkg::SECOND_VALID;

endmodule

`default_nettype wire

// ===== rtl/lcie_irq_gate.sv
/*
 * Masks every channel's sticky status bits and merges them into the one
 * registered interrupt level. Assumes a mask bit of one blocks its source.
 */
`timescale 1ns/100ps
`default_nettype none

module lcie_irq_gate (
    input  wire logic                                        ref_clk,
    input  wire logic                                        nrst,
    input  wire lcie_pkg::lcie_pair_s [lcie_pkg::CH_NUM-1:0] stickyVec,
    input  wire lcie_pkg::lcie_pair_s [lcie_pkg::CH_NUM-1:0] maskVec,
    output logic                                             irqOut
);

    lcie_pkg::lcie_gate_state_s state_ff;
    lcie_pkg::lcie_gate_state_s nxt_state;

    always_comb begin
        nxt_state.irq = 1'b0;
        for (int c = 0; c < lcie_pkg::CH_NUM; c++) begin
            nxt_state.irq = nxt_state.irq |
                            (|(stickyVec[c].first & ~maskVec[c].first)) |            // RL23
                            (|(stickyVec[c].second & ~maskVec[c].second));           // RL23
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign irqOut = state_ff.irq;

endmodule

`default_nettype wire

// ===== tb/lcie_line_channel_irq_props.sv
/* Assertions on the ports of the interrupt trigger block.
   Assumes one clock and the active-low asynchronous reset. */
`timescale 1ns/100ps
`default_nettype none
module lcie_line_channel_irq_props (
    input wire logic                                        ref_clk,
    input wire logic                                        nrst,
    input wire lcie_pkg::lcie_bus_req_s                     busReq,
    input wire logic [7:0]                                  busRdData,
    input wire lcie_pkg::lcie_pair_s [lcie_pkg::CH_NUM-1:0] liveStatus,
    input wire logic                                        irqOut
);
    logic       noWr_ff;
    logic [5:0] off;
    assign off = busReq.addr[5:0];
    // Reset values can only be judged until software writes anything.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            noWr_ff <= 1'b1;
        end else if (busReq.wrStb) begin
            noWr_ff <= 1'b0;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    AST_RD_IDLE: assert property (!$past(busReq.rdStb) |-> busRdData == 8'h00)
        else $error("read data not idle");
    AST_EDGE_RST: assert property (noWr_ff && busReq.rdStb && off == 6'h1a |=> busRdData == 8'h00)
        else $error("edge select reset value");
    AST_MASK1_RST: assert property (noWr_ff && busReq.rdStb && off == 6'h1b |=> busRdData == 8'hff)
        else $error("first mask reset value");
    AST_MASK2_RST: assert property (noWr_ff && busReq.rdStb && off == 6'h1c |=> busRdData == 8'he3)
        else $error("second mask reset value");
    AST_UNMAPPED: assert property (busReq.rdStb && (off < 6'h1a || off > 6'h21 || off == 6'h1d)
        |=> busRdData == 8'h00)
        else $error("unmapped read not zero");
    AST_RESERVED: assert property (busReq.rdStb && off == 6'h1c |=> busRdData[4:2] == 3'h0)
        else $error("reserved mask bits not zero");
    AST_EDGE_B7: assert property (busReq.rdStb && off == 6'h1a |=> !busRdData[7])
        else $error("edge select bit 7 not zero");
    AST_WR_RD: assert property (busReq.wrStb && off == 6'h1b ##1 busReq.rdStb && busReq.addr == $past(busReq.addr)
        |=> busRdData == $past(busReq.wrData, 2))
        else $error("mask write not read back");
    AST_MASKED_QUIET: assert property (noWr_ff |-> !irqOut)
        else $error("interrupt while all sources masked");
    cover property ($rose(irqOut));
    cover property ($fell(irqOut));
    cover property (busReq.wrStb && off == 6'h20);
endmodule
bind lcie_line_channel_irq lcie_line_channel_irq_props i_lcie_line_channel_irq_props (.ref_clk(ref_clk),
    .nrst(nrst), .busReq(busReq), .busRdData(busRdData), .liveStatus(liveStatus), .irqOut(irqOut));
`default_nettype wire

// ===== tb/tb_lcie_line_channel_irq.sv
/* Self-checking bench for the interrupt trigger block.
   Assumes the bound checker and a 250 MHz clock. */
`timescale 1ns/100ps
`default_nettype none
module tb_lcie_line_channel_irq;
    logic                                        ref_clk    = 1'b0;
    logic                                        nrst       = 1'b0;
    lcie_pkg::lcie_bus_req_s                     busReq     = '0;
    lcie_pkg::lcie_pair_s [lcie_pkg::CH_NUM-1:0] liveStatus = '0;
    logic [7:0]                                  busRdData;
    logic                                        irqOut;
    int                                          miscompares = 0;
    int                                          n_tests     = 0;
    int                                          cycles      = 0;
    always #2 ref_clk = ~ref_clk;
    lcie_line_channel_irq i_lcie_line_channel_irq (.ref_clk(ref_clk), .nrst(nrst), .busReq(busReq),
        .busRdData(busRdData), .liveStatus(liveStatus), .irqOut(irqOut));
    // ********************
    // Bus and check tasks
    // ********************
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        busReq <= '{1'b1, 1'b0, a, d};
        @(posedge ref_clk);
        busReq.wrStb <= 1'b0;
    endtask
    task automatic rd(input logic [9:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        busReq <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge ref_clk);
        busReq.rdStb <= 1'b0;
        #1;
        check(busRdData, e);
    endtask
    // A write followed at once by a read of the same address, with no idle cycle.
    task automatic wr_rd(input logic [9:0] a, input logic [7:0] d, input logic [7:0] e);
        @(posedge ref_clk);
        busReq <= '{1'b1, 1'b0, a, d};
        @(posedge ref_clk);
        busReq <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge ref_clk);
        busReq.rdStb <= 1'b0;
        #1;
        check(busRdData, e);
    endtask
    task automatic final_report();
        if (miscompares == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic t_reset();
        // Channel 3 raises every source while all masks still hold their reset value.
        liveStatus[3] <= '{8'hff, 8'hff};
        for (int c = 0; c < 16; c += 15) begin
            rd({c[3:0], 6'h1a}, 8'h00);
            rd({c[3:0], 6'h1b}, 8'hff);
            rd({c[3:0], 6'h1c}, 8'he3);
            rd({c[3:0], 6'h20}, 8'h00);
            rd({c[3:0], 6'h1d}, 8'h00);
        end
        rd(10'h0e0, 8'hff);
        rd(10'h0e1, 8'he3);
        irq_is(1'b0);
    endtask
    task automatic t_edges();
        logic [7:0] sel [4] = '{8'h00, 8'hff, 8'h55, 8'h2a};
        for (int k = 0; k < 4; k++) begin
            wr(10'h15a, sel[k]);
            rd(10'h15a, sel[k] & 8'h7f);
            @(posedge ref_clk);
            liveStatus[5] <= '{8'hff, 8'hff};
            repeat (3) @(posedge ref_clk);
            rd(10'h160, 8'hff);
            rd(10'h161, 8'he3);
            rd(10'h15e, 8'h1f);
            rd(10'h15f, 8'he3);
            wr(10'h160, 8'hff);
            wr(10'h161, 8'hff);
            rd(10'h160, 8'h00);
            rd(10'h161, 8'h00);
            rd(10'h1a0, 8'h00);
            @(posedge ref_clk);
            liveStatus[5] <= '0;
            repeat (3) @(posedge ref_clk);
            rd(10'h160, {3'h0, sel[k][4:1], sel[k][1]});
            rd(10'h161, {{2{sel[k][6]}}, sel[k][5], 3'h0, {2{sel[k][0]}}});
            wr(10'h160, 8'hff);
            wr(10'h161, 8'hff);
        end
    endtask
    task automatic irq_is(input logic e);
        repeat (2) @(posedge ref_clk);
        #1;
        check({7'h0, irqOut}, {7'h0, e});
    endtask
    task automatic t_irq();
        logic [15:0] en;
        @(posedge ref_clk);
        liveStatus[9] <= '{8'hff, 8'hff};
        // Each source alone is let through; reserved second bits must stay quiet.
        for (int j = 0; j < 16; j++) begin
            en = ~(16'h1 << j);
            wr(10'h25b, en[7:0]);
            wr(10'h25c, en[15:8]);
            irq_is((j < 8) ? 1'b1 : lcie_pkg::SECOND_VALID[j[2:0]]);
        end
        wr_rd(10'h25b, 8'hff, 8'hff);
        wr_rd(10'h25c, 8'hff, 8'he3);
        irq_is(1'b0);
        wr(10'h25b, 8'h00);
        wr(10'h25c, 8'h00);
        irq_is(1'b1);
        wr(10'h260, 8'hff);
        wr(10'h261, 8'hff);
        irq_is(1'b0);
        @(posedge ref_clk);
        liveStatus[9] <= '0;
        irq_is(1'b0);
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            final_report();
        end
    end
    initial begin
        repeat (10) @(posedge ref_clk);
        nrst <= 1'b1;
        t_reset();
        t_edges();
        t_irq();
        final_report();
    end
endmodule
`default_nettype wire
